// ### shared/modem_regs_consts.svh
`ifndef MODEM_REGS_CONSTS_SVH
`define MODEM_REGS_CONSTS_SVH

`define ADDR_GENERAL_RESET   8'h01
`define ADDR_GENERAL_CONTROL 8'hE0
`define ADDR_TRANSMIT_MODE   8'hE1
`define GC_RESET_VALUE       16'h0000
`define TM_RESET_VALUE       16'h0000
`define GC_TXINV_OFF         15
`define GC_TXTRUE_OFF        14
`define GC_LOOPBACK          11
`define GC_EQ_DISABLE        10
`define GC_POWERUP           8
`define GC_RESET             7
`define GC_IRQ_EN            6
`define GC_MASK_HI           4
`define GC_MASK_LO           0
`define TM_MODE_HI           15
`define TM_MODE_LO           12
`define TM_LEVEL_HI          11
`define TM_LEVEL_LO          9
`define TM_TWIST_HI          7
`define TM_TWIST_LO          5
`define TM_FMT_HI            4
`define TM_FMT_LO            3
`define TM_LOW_HI            4
`define TM_LOW_LO            0
`define LEVEL_STEP_HALF_DB   5'h03
`define LEVEL_MAX_CODE       5'h07

`endif

// ### shared/modem_regs_pkg.sv
package modem_regs_pkg;

	typedef enum logic [3:0] {
		TXM_DISABLED  = 4'b0000,
		TXM_TONES     = 4'b0001,
		TXM_B202_150  = 4'b0010,
		TXM_B202_1200 = 4'b0011,
		TXM_V23_75    = 4'b0100,
		TXM_V23_1200  = 4'b0101,
		TXM_B103_LO   = 4'b0110,
		TXM_B103_HI   = 4'b0111,
		TXM_V21_LO    = 4'b1000,
		TXM_V21_HI    = 4'b1001
	} tx_mode_t;

	typedef enum logic [1:0] {
		FMT_ODD_PARITY  = 2'b00,
		FMT_EVEN_PARITY = 2'b01,
		FMT_NO_PARITY   = 2'b10,
		FMT_SYNC        = 2'b11
	} tx_format_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_HI   = 3'b010,
		ST_LO   = 3'b011,
		ST_DONE = 3'b100
	} bus_state_t;

	typedef struct packed {
		logic loopback_select;
		logic eq_disable;
		logic powerup;
		logic bias_supply;
		logic internal_reset;
		logic irq_pin_enable;
	} ctrl_t;

	typedef struct packed {
		tx_mode_t   mode;
		logic [2:0] level;
		logic [2:0] twist;
		tx_format_t format;
		logic [4:0] low_field;
		logic       is_dtmf;
		logic       is_modem;
	} tx_cfg_t;

endpackage : modem_regs_pkg

// ### rtl/modem_general_and_tx_mode_regs.sv
`include "modem_regs_consts.svh"

module modem_general_and_tx_mode_regs
	import modem_regs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       cmd_data,
	input  wire logic [4:0] status_events,
	input  wire logic       tone_active,
	output logic            inverted_tx_output_oe_n,
	output logic            true_tx_output_oe_n,
	output logic            irq_n_out,
	output logic            irq_n_oe_n,
	output ctrl_t           ctrl,
	output tx_cfg_t         tx_cfg,
	output logic [4:0]      tx_atten_half_db,
	output logic [3:0]      twist_half_db,
	output logic            status_irq,
	output logic            general_reset_pulse
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [3:0] twist_gain(input logic [2:0] code);
		case (code)
			3'h0:    twist_gain = 4'h4;
			3'h1:    twist_gain = 4'h2;
			3'h2:    twist_gain = 4'h3;
			3'h3:    twist_gain = 4'h5;
			3'h4:    twist_gain = 4'h6;
			3'h5:    twist_gain = 4'h7;
			3'h6:    twist_gain = 4'h8;
			default: twist_gain = 4'h9;
		endcase
	endfunction : twist_gain

	function automatic logic [4:0] level_atten(input logic [2:0] code);
		level_atten = 5'((`LEVEL_MAX_CODE - {2'h0, code}) * `LEVEL_STEP_HALF_DB);
	endfunction : level_atten

	// ****************************************
	// Serial receiver
	// ****************************************
	bus_state_t state;
	bus_state_t next_state;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] addr;
	logic [7:0] next_addr;
	logic [7:0] data_hi;
	logic [7:0] next_data_hi;
	logic       sclk_prev;
	logic       sclk_rise;
	logic       byte_done;
	logic [7:0] byte_in;
	logic       wr_gc;
	logic       wr_tm;
	logic       gen_reset;
	logic [15:0] wdata;

	assign sclk_rise = sclk && !sclk_prev;
	assign byte_in   = {shift[6:0], cmd_data};
	assign byte_done = !cs_n && sclk_rise && (bit_cnt == 3'h7);
	assign wdata     = {data_hi, byte_in};

	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shift   = shift;
		next_addr    = addr;
		next_data_hi = data_hi;
		wr_gc        = 1'b0;
		wr_tm        = 1'b0;
		gen_reset    = 1'b0;
		if (cs_n) begin
			// Chip select high aborts any partial transfer
			next_state   = ST_IDLE;
			next_bit_cnt = 3'h0;
		end else if (sclk_rise) begin
			next_shift   = byte_in;
			next_bit_cnt = bit_cnt + 3'h1;
			case (state)
				ST_IDLE, ST_ADDR: begin
					next_state = ST_ADDR;
					if (byte_done) begin
						next_addr = byte_in;
						gen_reset = (byte_in == `ADDR_GENERAL_RESET);
						next_state = ST_HI;
					end
				end
				ST_HI: begin
					if (byte_done) begin
						next_data_hi = byte_in;
						next_state   = ST_LO;
					end
				end
				ST_LO: begin
					if (byte_done) begin
						// Commit only with both bytes so no half field takes effect
						wr_gc      = (addr == `ADDR_GENERAL_CONTROL);
						wr_tm      = (addr == `ADDR_TRANSMIT_MODE);
						next_state = ST_DONE;
					end
				end
				ST_DONE: next_state = ST_DONE;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			bit_cnt   <= 3'h0;
			shift     <= 8'h00;
			addr      <= 8'h00;
			data_hi   <= 8'h00;
			sclk_prev <= 1'b0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			addr      <= next_addr;
			data_hi   <= next_data_hi;
			sclk_prev <= sclk;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] gc;
	logic [15:0] next_gc;
	logic [15:0] tm;
	logic [15:0] next_tm;
	logic [2:0]  twist_applied;
	logic [2:0]  next_twist_applied;
	logic        next_status_irq;

	always_comb begin
		next_gc = gc;
		next_tm = tm;
		if (wr_gc) begin
			next_gc = wdata;
		end
		if (wr_tm) begin
			next_tm = wdata;
		end
		if (gen_reset) begin
			next_gc = `GC_RESET_VALUE;
			next_tm = `TM_RESET_VALUE;
		end
		// Reset bit wins over a transmit mode write landing the same cycle
		if (next_gc[`GC_RESET]) begin
			next_tm = `TM_RESET_VALUE;
		end
		// Twist never changes mid-tone, so hold it while a tone plays
		next_twist_applied = twist_applied;
		if (!tone_active) begin
			next_twist_applied = tm[`TM_TWIST_HI:`TM_TWIST_LO];
		end
		next_status_irq = |(status_events & gc[`GC_MASK_HI:`GC_MASK_LO]);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gc                  <= `GC_RESET_VALUE;
			tm                  <= `TM_RESET_VALUE;
			twist_applied       <= 3'h0;
			status_irq          <= 1'b0;
			general_reset_pulse <= 1'b0;
		end else begin
			gc                  <= next_gc;
			tm                  <= next_tm;
			twist_applied       <= next_twist_applied;
			status_irq          <= next_status_irq;
			general_reset_pulse <= gen_reset;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign inverted_tx_output_oe_n = gc[`GC_TXINV_OFF];
	assign true_tx_output_oe_n     = gc[`GC_TXTRUE_OFF];
	assign irq_n_out               = 1'b0;
	assign irq_n_oe_n = !(gc[`GC_IRQ_EN] && status_irq);

	always_comb begin
		ctrl.loopback_select = gc[`GC_LOOPBACK];
		ctrl.eq_disable      = gc[`GC_EQ_DISABLE];
		// Powersave drops only the powerup and bias supply controls; the registers and interrupt path keep running
		ctrl.powerup         = gc[`GC_POWERUP];
		ctrl.bias_supply     = gc[`GC_POWERUP];
		ctrl.internal_reset  = gc[`GC_RESET];
		ctrl.irq_pin_enable  = gc[`GC_IRQ_EN];
		tx_cfg.mode      = tx_mode_t'(tm[`TM_MODE_HI:`TM_MODE_LO]);
		tx_cfg.level     = tm[`TM_LEVEL_HI:`TM_LEVEL_LO];
		tx_cfg.twist     = twist_applied;
		tx_cfg.format    = tx_format_t'(tm[`TM_FMT_HI:`TM_FMT_LO]);
		tx_cfg.low_field = tm[`TM_LOW_HI:`TM_LOW_LO];
		tx_cfg.is_dtmf   = (tm[`TM_MODE_HI:`TM_MODE_LO] == TXM_TONES);
		tx_cfg.is_modem  = (tm[`TM_MODE_HI:`TM_MODE_LO] > TXM_TONES)
			&& (tm[`TM_MODE_HI:`TM_MODE_LO] <= TXM_V21_HI);
	end

	assign tx_atten_half_db = level_atten(tm[`TM_LEVEL_HI:`TM_LEVEL_LO]);
	assign twist_half_db    = twist_gain(twist_applied);

	// ****************************************
	// Assertions
	// ****************************************
	property p_inv_off;
		@(posedge core_clk) disable iff (!rst_n)
		wr_gc |=> inverted_tx_output_oe_n == $past(wdata[15]);
	endproperty
	a_inv_off: assert property (p_inv_off) else $error("inverted output enable wrong");

	property p_true_off;
		@(posedge core_clk) disable iff (!rst_n)
		wr_gc |=> true_tx_output_oe_n == $past(wdata[14]);
	endproperty
	a_true_off: assert property (p_true_off) else $error("true output enable wrong");

	property p_loop_eq;
		@(posedge core_clk) disable iff (!rst_n)
		wr_gc |=> ctrl.loopback_select == $past(wdata[11])
			&& ctrl.eq_disable == $past(wdata[10]);
	endproperty
	a_loop_eq: assert property (p_loop_eq) else $error("loopback or equaliser wrong");

	property p_gen_reset;
		@(posedge core_clk) disable iff (!rst_n)
		gen_reset |=> !ctrl.powerup && gc == 16'h0000 && tm == 16'h0000 && general_reset_pulse;
	endproperty
	a_gen_reset: assert property (p_gen_reset) else $error("general reset did not clear");

	property p_reset_hold;
		@(posedge core_clk) disable iff (!rst_n)
		ctrl.internal_reset && !wr_gc && !gen_reset |=> tm == 16'h0000;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("mode kept during reset");

	property p_irq_pin;
		@(posedge core_clk) disable iff (!rst_n)
		(|(status_events & gc[4:0])) && gc[6] && !wr_gc && !gen_reset |=> !irq_n_oe_n;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not driven");

	property p_whole_write;
		@(posedge core_clk) disable iff (!rst_n)
		!$stable(tm) |-> $past(wr_tm || gen_reset || next_gc[7]);
	endproperty
	a_whole_write: assert property (p_whole_write) else $error("partial mode update");

	property p_twist_hold;
		@(posedge core_clk) disable iff (!rst_n)
		tone_active |=> $stable(twist_applied);
	endproperty
	a_twist_hold: assert property (p_twist_hold) else $error("twist changed mid-tone");

	property p_abort;
		@(posedge core_clk) disable iff (!rst_n)
		cs_n |=> state == ST_IDLE && bit_cnt == 3'h0;
	endproperty
	a_abort: assert property (p_abort) else $error("frame abort left state");

	property p_tm_write;
		@(posedge core_clk) disable iff (!rst_n)
		wr_tm && !gc[`GC_RESET] |=> tm == $past(wdata);
	endproperty
	a_tm_write: assert property (p_tm_write) else $error("mode write lost");

	property p_mask;
		@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> status_irq == $past(|(status_events & gc[`GC_MASK_HI:`GC_MASK_LO]));
	endproperty
	a_mask: assert property (p_mask) else $error("summary interrupt mask wrong");

	property p_irq_off;
		@(posedge core_clk) disable iff (!rst_n)
		!gc[`GC_IRQ_EN] |-> irq_n_oe_n;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("pin driven while disabled");

	property p_twist_follow;
		@(posedge core_clk) disable iff (!rst_n)
		!tone_active |=> twist_applied == $past(tm[`TM_TWIST_HI:`TM_TWIST_LO]);
	endproperty
	a_twist_follow: assert property (p_twist_follow) else $error("twist not applied");

	c_write_gc: cover property (@(posedge core_clk) disable iff (!rst_n) wr_gc);
	c_write_tm: cover property (@(posedge core_clk) disable iff (!rst_n) wr_tm && !gc[7]);
	c_gen_reset: cover property (@(posedge core_clk) disable iff (!rst_n) gen_reset && gc[8]);
	c_abort: cover property (@(posedge core_clk) disable iff (!rst_n) cs_n && state == ST_LO);
	c_tone_hold: cover property (@(posedge core_clk) disable iff (!rst_n) tone_active && wr_tm);

endmodule : modem_general_and_tx_mode_regs

// ### test/serial_host.sv
module serial_host (
	input  wire logic core_clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      cmd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// Host side of the serial bus
	// ********************************

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		cmd_data = 1'b1;
	end

	// Sends the top n bits of w; 8 sends a lone command byte, 16 models an aborted frame
	task automatic shift(input logic [23:0] w, input int n);
		@(posedge core_clk) cs_n <= 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			@(posedge core_clk) begin
				sclk <= 1'b0;
				cmd_data <= w[i];
			end
			@(posedge core_clk) sclk <= 1'b1;
		end
		@(posedge core_clk) sclk <= 1'b0;
		// Released line shows the inverse so a stale bit is never mistaken for data
		@(posedge core_clk) begin
			cs_n <= 1'b1;
			cmd_data <= ~cmd_data;
		end
		@(posedge core_clk);
		#1;
	endtask : shift

	// Address, high byte, low byte under one chip select
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		shift({a, d}, 24);
	endtask : write_reg

	// Address byte alone in an 8-bit frame, as for the general reset command
	task automatic command(input logic [7:0] a);
		shift({a, 16'h0000}, 8);
	endtask : command
endmodule : serial_host

// ### test/tb_top.sv
module tb_top import modem_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// Bench
	// ********************************

	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       tone_active = 1'b0;
	logic [4:0] status_events = 5'h00;
	logic       cs_n, sclk, cmd_data, inv_oe_n, true_oe_n, irq_n_oe_n, status_irq;
	ctrl_t      ctrl;
	tx_cfg_t    tx_cfg;
	logic [4:0] tx_atten_half_db;
	logic [3:0] twist_half_db;
	logic       irq_n_out, reset_pulse;
	int         n_pulse = 0;
	int         n_mismatch = 0;
	int         cmp_count = 0;
	logic [3:0] twist_tab [8] = '{4'h4, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

	always #2.5 core_clk = ~core_clk;

	// One-cycle pulse, so it is counted on the falling edge where it stands settled
	always @(negedge core_clk) begin
		if (reset_pulse === 1'b1) begin
			n_pulse++;
		end
	end

	serial_host host_u (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .cmd_data(cmd_data));

	modem_general_and_tx_mode_regs dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .cmd_data(cmd_data),
		.status_events(status_events), .tone_active(tone_active),
		.inverted_tx_output_oe_n(inv_oe_n), .true_tx_output_oe_n(true_oe_n),
		.irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n), .ctrl(ctrl), .tx_cfg(tx_cfg),
		.tx_atten_half_db(tx_atten_half_db), .twist_half_db(twist_half_db),
		.status_irq(status_irq), .general_reset_pulse(reset_pulse)
	);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_gc(input logic [15:0] e);
		chk("inv_oe_n", e[15], inv_oe_n);
		chk("true_oe_n", e[14], true_oe_n);
		chk("ctrl", {e[11], e[10], e[8], e[8], e[7], e[6]}, ctrl);
	endtask : chk_gc

	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	initial begin
		#200us;
		n_mismatch++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		settle();
		chk_gc(16'h0000);
		chk("atten", 16'd21, tx_atten_half_db);
		chk("twist", 16'd4, twist_half_db);
		host_u.command(8'h01);
		host_u.write_reg(8'hE0, 16'h0180);
		chk_gc(16'h0180);
		host_u.write_reg(8'hE1, 16'h1E00);
		chk("mode in reset", 16'h0, tx_cfg.mode);
		host_u.write_reg(8'hE0, 16'hCD5F);
		chk_gc(16'hCD5F);
		// Mode codes 0 to 11, the ten defined and two undefined; twist 0 keeps the level pairing legal
		for (int i = 0; i < 12; i++) begin
			host_u.write_reg(8'hE1, {i[3:0], i[2:0], 1'b0, 3'b000, i[1:0], 3'b101});
			chk("mode", i[15:0], tx_cfg.mode);
			chk("level", i[2:0], tx_cfg.level);
			chk("atten", 16'((7 - (i % 8)) * 3), tx_atten_half_db);
			chk("format", i[1:0], tx_cfg.format);
			chk("dtmf", i == 1, tx_cfg.is_dtmf);
			chk("modem", i > 1 && i < 10, tx_cfg.is_modem);
		end
		for (int t = 0; t < 8; t++) begin
			host_u.write_reg(8'hE1, {4'h1, 3'b000, 1'b0, t[2:0], 5'h15});
			chk("twist", twist_tab[t], twist_half_db);
			chk("twist code", t[2:0], tx_cfg.twist);
			chk("tone select", 16'h15, tx_cfg.low_field);
		end
		@(posedge core_clk) tone_active <= 1'b1;
		host_u.write_reg(8'hE1, 16'h1015);
		chk("twist mid tone", 16'h9, twist_half_db);
		@(posedge core_clk) tone_active <= 1'b0;
		settle();
		chk("twist after tone", 16'h4, twist_half_db);
		host_u.write_reg(8'hE0, 16'h0144);
		@(posedge core_clk) status_events <= 5'h1B;
		settle();
		chk("masked irq", 16'h0, status_irq);
		chk("irq pin idle", 16'h1, irq_n_oe_n);
		@(posedge core_clk) status_events <= 5'h04;
		settle();
		chk("irq", 16'h1, status_irq);
		chk("irq pin", 16'h0, irq_n_oe_n);
		chk("irq pin level", 16'h0, irq_n_out);
		host_u.write_reg(8'hE0, 16'h0104);
		chk("irq pin off", 16'h1, irq_n_oe_n);
		host_u.shift({8'hE0, 16'hC000}, 16);
		chk_gc(16'h0104);
		host_u.write_reg(8'hE1, 16'h9018);
		chk("mode before reset bit", 16'h9, tx_cfg.mode);
		chk("format before reset bit", 16'h3, tx_cfg.format);
		host_u.write_reg(8'hE0, 16'h0180);
		chk("mode after reset bit", 16'h0, tx_cfg.mode);
		host_u.write_reg(8'hE0, 16'hC100);
		host_u.write_reg(8'hE1, 16'h9018);
		chk("mode before general reset", 16'h9, tx_cfg.mode);
		host_u.command(8'h01);
		chk_gc(16'h0000);
		chk("mode after general reset", 16'h0, tx_cfg.mode);
		chk("reset pulses", 16'd2, 16'(n_pulse));
		test_done();
	end
endmodule : tb_top
